/* hw/mcg_master_clock.sv */
// Purpose: master, cpu and system clock enables from the oscillator pin
// Assumes: oscillator pin is asynchronous and well below clk/2
// Notes: derived clocks are one-cycle enables on clk, except masterLevel in one-to-one bypass
//
// How it works
// - cpu clock is master clock or half of it, one select bit
// - cpu and external bus controller both run from the cpu clock
// - peripheral system clock has the cpu clock frequency
// - bypass: master = oscillator / ((input div+1)*(output div+1))
// - bypass with both dividers zero: master follows oscillator level
// - input divider up to 3, output divider up to 14
// - mode 11 enables the loop and takes master from its output
// - loop mode: master = osc*(mul+1)/((idiv+1)*(odiv+1))
// - loop adjusts its frequency in small steps, never abruptly
// - missing oscillator in monitored bypass: interrupt, emergency clock
// - loop off disables oscillator monitoring and its interrupt
//
// The Wishbone interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ns
`default_nettype none
module mcg_master_clock (
   input wire logic clk,
   input wire logic reset,
   input wire logic oscillatorInputPin,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output mcg_pkg::mcg_ticks_s ticks,
   output logic emergencyClock,
   output logic loopLocked,
   output logic irq
);
   import mcg_pkg::*;

   // =====================================================
   // registers
   logic [15:0] configReg;
   logic [IRQ_W-1:0] statusReg;
   logic [IRQ_W-1:0] maskReg;
   logic [IRQ_W-1:0] eventSet;
   mcg_cfg_s cfg;
   mcg_cfg_s active;
   logic busWrite;
   logic busRead;
   logic cpuPhase;
   logic cpuTick;

   assign cfg = mcg_cfg_s'(configReg[13:0]);
   assign busWrite = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
   assign busRead = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;

   always_ff @(posedge clk) begin
      if (reset) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         configReg <= CONFIG_RESET;
      end else if (busWrite && wb_adr_i == ADDR_CONFIG) begin
         if (wb_sel_i[0]) begin
            configReg[7:0] <= wb_dat_i[7:0];
         end
         if (wb_sel_i[1]) begin
            configReg[13:8] <= wb_dat_i[13:8];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         maskReg <= MASK_RESET;
      end else if (busWrite && wb_adr_i == ADDR_MASK && wb_sel_i[0]) begin
         maskReg <= wb_dat_i[IRQ_W-1:0];
      end
   end

   // set wins over a same-cycle write-one clear
   always_ff @(posedge clk) begin
      if (reset) begin
         statusReg <= '0;
      end else if (busWrite && wb_adr_i == ADDR_STATUS && wb_sel_i[0]) begin
         statusReg <= (statusReg & ~wb_dat_i[IRQ_W-1:0]) | eventSet;
      end else begin
         statusReg <= statusReg | eventSet;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (busRead) begin
         unique case (wb_adr_i)
            ADDR_CONFIG: wb_dat_o <= {18'h0_0000, configReg[13:0]};
            ADDR_STATUS: wb_dat_o <= {30'h0000_0000, statusReg};
            ADDR_MASK: wb_dat_o <= {30'h0000_0000, maskReg};
            ADDR_STATE: wb_dat_o <= {16'h0000, active[13:0],
               emergencyClock, loopLocked};
            default: wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   assign irq = |(statusReg & maskReg);

   // =====================================================
   // oscillator pin synchroniser and edge
   logic oscMeta;
   logic oscSync;
   logic oscLast;
   logic oscEdge;

   always_ff @(posedge clk) begin
      if (reset) begin
         oscMeta <= 1'b0;
         oscSync <= 1'b0;
         oscLast <= 1'b0;
      end else begin
         oscMeta <= oscillatorInputPin;
         oscSync <= oscMeta;
         oscLast <= oscSync;
      end
   end
   assign oscEdge = oscSync & ~oscLast;

   // =====================================================
   // input prescaler gives the reference edge
   logic [1:0] idivCount;
   logic refEdge;
   logic masterTick;

   assign refEdge = oscEdge && idivCount == active.inputPrescaleField;

   always_ff @(posedge clk) begin
      if (reset) begin
         idivCount <= 2'h0;
      end else if (refEdge) begin
         idivCount <= 2'h0;
      end else if (oscEdge) begin
         idivCount <= idivCount + 2'h1;
      end
   end

   // =====================================================
   // loop: frequency-locked oscillator on a phase accumulator
   logic loopOn;
   logic loopPath;
   logic [15:0] ncoAcc;
   logic [15:0] ncoInc;
   logic ncoTick;
   logic [16:0] ncoSum;
   logic [7:0] tickCount;
   logic [7:0] tickTarget;

   assign loopPath = active.clockPathModeField == MODE_PLL;
   assign loopOn = loopPath || active.clockPathModeField == MODE_BYPASS_MON;
   assign ncoSum = {1'b0, ncoAcc} + {1'b0, ncoInc};
   assign ncoTick = loopOn & ncoSum[16];
   assign tickTarget = {3'h0, active.loopMultiplierField} + 8'h01;

   always_ff @(posedge clk) begin
      if (reset || !loopOn) begin
         ncoAcc <= 16'h0000;
      end else begin
         ncoAcc <= ncoSum[15:0];
      end
   end

   always_ff @(posedge clk) begin
      if (reset || !loopOn) begin
         tickCount <= 8'h00;
      end else if (refEdge) begin
         // the edge cycle's own tick opens the next window, none lost
         tickCount <= {7'h00, ncoTick};
      end else if (ncoTick && tickCount != 8'hFF) begin
         tickCount <= tickCount + 8'h01;
      end
   end

   // one small step per reference edge
   // lock to (mul+1) loop ticks per reference
   always_ff @(posedge clk) begin
      if (reset || !loopOn) begin
         ncoInc <= NCO_BASE_INC;
         loopLocked <= 1'b0;
      end else if (emergencyClock) begin
         ncoInc <= NCO_BASE_INC;
         loopLocked <= 1'b0;
      end else if (loopPath && refEdge) begin
         loopLocked <= tickCount == tickTarget;
         if (tickCount < tickTarget && ncoInc < NCO_MAX_INC) begin
            ncoInc <= ncoInc + NCO_STEP;
         end else if (tickCount > tickTarget && ncoInc > NCO_MIN_INC) begin
            ncoInc <= ncoInc - NCO_STEP;
         end
      end
   end

   // =====================================================
   // oscillator watchdog
   logic [7:0] wdogCount;
   logic lockedLast;

   // missing edges in monitored bypass switch to loop base clock
   always_ff @(posedge clk) begin
      if (reset || !loopOn || oscEdge) begin
         wdogCount <= 8'h00;
      end else if (wdogCount != WDOG_CYCLES) begin
         wdogCount <= wdogCount + 8'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (reset || !loopOn) begin
         emergencyClock <= 1'b0;
      end else if (wdogCount == WDOG_CYCLES && !loopPath) begin
         emergencyClock <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         lockedLast <= 1'b0;
      end else begin
         lockedLast <= loopLocked;
      end
   end

   always_comb begin
      eventSet = '0;
      eventSet[IRQ_WDOG_POS] = loopOn && !loopPath && !emergencyClock &&
         wdogCount == WDOG_CYCLES;
      eventSet[IRQ_LOCK_POS] = loopLocked & ~lockedLast;
   end

   // =====================================================
   // output prescaler and master clock
   logic [3:0] odivCount;
   logic preTick;
   logic oneToOne;

   // bypass feeds reference, loop and emergency clock feed loop ticks
   assign preTick = (loopPath || emergencyClock) ? ncoTick : refEdge;
   assign masterTick = preTick && odivCount == active.outputPrescaleField;
   assign oneToOne = !loopPath && !emergencyClock &&
      active.inputPrescaleField == 2'h0 && active.outputPrescaleField == 4'h0;

   always_ff @(posedge clk) begin
      if (reset || masterTick) begin
         odivCount <= 4'h0;
      end else if (preTick) begin
         odivCount <= odivCount + 4'h1;
      end
   end

   // settings move to the active copy on a master tick, or with the loop off, pin low and both counts zero
   always_ff @(posedge clk) begin
      if (reset) begin
         active <= mcg_cfg_s'(CONFIG_RESET[13:0]);
      end else if (masterTick || (!oscSync && idivCount == 2'h0 &&
            odivCount == 4'h0 && !loopOn)) begin
         active <= cfg;
         if (cfg.outputPrescaleField > ODIV_MAX) begin
            active.outputPrescaleField <= ODIV_MAX;
         end
         active.cpuClockHalveSelect <= cpuPhase ?
            active.cpuClockHalveSelect : cfg.cpuClockHalveSelect;
      end
   end

   // =====================================================
   // cpu, bus and system enables
   // halve when select set
   assign cpuTick = masterTick & (~active.cpuClockHalveSelect | cpuPhase);

   // halve phase restarts only at a cpu edge
   always_ff @(posedge clk) begin
      if (reset) begin
         cpuPhase <= 1'b0;
      end else if (masterTick) begin
         cpuPhase <= active.cpuClockHalveSelect & ~cpuPhase;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         ticks <= '0;
      end else begin
         ticks.masterTick <= masterTick;
         ticks.cpuTick <= cpuTick;
         ticks.busTick <= cpuTick;
         ticks.sysTick <= cpuTick;
         ticks.masterLevel <= oneToOne ? oscSync : masterTick;
      end
   end
endmodule : mcg_master_clock
`default_nettype wire

/* hw/mcg_pkg.sv */
// Purpose: shared constants and types of the master clock generator
// Assumes: one 125 MHz clock, classic Wishbone register access
// Notes: field layout of the control register lives here
package mcg_pkg;
   // =====================================================
   // register offsets (byte addresses)
   localparam logic [3:0] ADDR_CONFIG = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_MASK = 4'h8;
   localparam logic [3:0] ADDR_STATE = 4'hC;
   // =====================================================
   // config field positions and output divider limit
   localparam int CFG_HALVE_POS = 0;
   localparam int CFG_MODE_POS = 1;
   localparam int CFG_IDIV_POS = 3;
   localparam int CFG_ODIV_POS = 5;
   localparam int CFG_MUL_POS = 9;
   localparam logic [3:0] ODIV_MAX = 4'hE;
   // =====================================================
   // status / mask bits
   localparam int IRQ_WDOG_POS = 0;
   localparam int IRQ_LOCK_POS = 1;
   localparam int IRQ_W = 2;
   // =====================================================
   // reset values, loop step and loop limits
   localparam logic [15:0] CONFIG_RESET = 16'h0000;
   localparam logic [IRQ_W-1:0] MASK_RESET = 2'h0;
   localparam logic [15:0] NCO_BASE_INC = 16'h2000;
   localparam logic [15:0] NCO_STEP = 16'h0010;
   localparam logic [15:0] NCO_MAX_INC = 16'hF000;
   localparam logic [15:0] NCO_MIN_INC = 16'h0100;
   // =====================================================
   // timing
   localparam int CLK_MHZ = 125;
   localparam int WDOG_TIMEOUT_NS = 500;
   localparam int WDOG_CYCLES_I = WDOG_TIMEOUT_NS * CLK_MHZ / 1000;
   localparam logic [7:0] WDOG_CYCLES = WDOG_CYCLES_I[7:0];
   // =====================================================
   // clock path modes
   typedef enum logic [1:0] {
      MODE_BYPASS = 2'b00,
      MODE_BYPASS_MON = 2'b01,
      MODE_BYPASS_ALT = 2'b10,
      MODE_PLL = 2'b11
   } mcg_mode_e;

   typedef struct packed {
      logic [4:0] loopMultiplierField;
      logic [3:0] outputPrescaleField;
      logic [1:0] inputPrescaleField;
      mcg_mode_e clockPathModeField;
      logic cpuClockHalveSelect;
   } mcg_cfg_s;

   typedef struct packed {
      logic masterTick;
      logic cpuTick;
      logic busTick;
      logic sysTick;
      logic masterLevel;
   } mcg_ticks_s;
endpackage : mcg_pkg

/* verification/mcg_properties.sv */
// Purpose: port-level checks of the master clock generator
// Assumes: one clock, synchronous active-high reset
// Notes: bound to mcg_master_clock
`timescale 1ns/1ns
`default_nettype none
module mcg_properties import mcg_pkg::*; (
   input wire logic clk,
   input wire logic reset,
   input wire logic oscillatorInputPin,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire mcg_pkg::mcg_ticks_s ticks,
   input wire logic emergencyClock,
   input wire logic loopLocked,
   input wire logic irq
);
   // =====================================================
   // helper: cycles since the raw pin last moved
   logic [7:0] quiet;
   logic oscLast;
   always_ff @(posedge clk) begin
      oscLast <= oscillatorInputPin;
      if (reset || oscLast != oscillatorInputPin) quiet <= 8'h00;
      else if (quiet != 8'hFF) quiet <= quiet + 8'h01;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // =====================================================
   // assertions
   a_ack_one_cycle: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack not one cycle after request");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property (
      wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_bus_cpu: assert property (ticks.busTick == ticks.cpuTick)
      else $error("bus tick differs from cpu tick");
   a_sys_cpu: assert property (ticks.sysTick == ticks.cpuTick)
      else $error("system tick differs from cpu tick");
   a_cpu_master: assert property (ticks.cpuTick |-> ticks.masterTick)
      else $error("cpu tick without master tick");
   // sync delay allowed for, so the bound is loose
   a_emerg_quiet: assert property (
      $rose(emergencyClock) |-> quiet >= 8'h32)
      else $error("fallback while oscillator active");
   a_reset_clear: assert property ($fell(reset) |-> !wb_ack_o &&
      !irq && !emergencyClock && !loopLocked && ticks == '0)
      else $error("outputs not clear after reset");
endmodule : mcg_properties
bind mcg_master_clock mcg_properties chk (.clk, .reset,
   .oscillatorInputPin, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .ticks,
   .emergencyClock, .loopLocked, .irq);
`default_nettype wire

/* verification/tb_top.sv */
// Purpose: self-checking bench of the master clock generator
// Assumes: bench drives every port, 125 MHz clock
// Notes: oscillator is a slow pattern stepped on clk
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import mcg_pkg::*;
   logic clk, reset, osc, cyc, stb, we, ack, irq, emerg, locked, oscOn;
   logic [3:0] adr;
   logic [31:0] wdat, rdat;
   mcg_ticks_s ticks;
   int oscHi, oscLo, oscPh, nMaster, nCpu, nLevel;
   int nMismatch, samplesChecked;
   mcg_master_clock dut (.clk, .reset, .oscillatorInputPin(osc),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .ticks, .emergencyClock(emerg), .loopLocked(locked), .irq);
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // =====================================================
   // oscillator pattern and tick counters
   always @(posedge clk) begin
      if (oscOn) begin
         oscPh <= (oscPh + 1 >= oscHi + oscLo) ? 0 : oscPh + 1;
         osc <= (oscPh < oscHi);
      end
      nMaster <= nMaster + int'(ticks.masterTick);
      nCpu <= nCpu + int'(ticks.cpuTick);
      nLevel <= nLevel + int'(ticks.masterLevel);
   end
   // =====================================================
   // shared tasks
   task automatic check(input logic ok, input string msg);
      samplesChecked++;
      if (ok !== 1'b1) begin
         nMismatch++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask : check
   task automatic wb(input logic w, input logic [3:0] a,
         input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat;
      check(n < 20, "bus timeout");
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] e,
         input logic [31:0] m, input string s);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      check((q & m) === e, s);
   endtask : rd
   task automatic oscSet(input logic on, input int hi, input int lo);
      @(posedge clk);
      oscOn <= on;
      oscHi <= hi;
      oscLo <= lo;
      oscPh <= 0;
   endtask : oscSet
   // =====================================================
   // scenarios
   task automatic t_regs;
      rd(ADDR_CONFIG, 32'h0, 32'hFFFF, "config reset");
      rd(ADDR_MASK, 32'h0, 32'h3, "mask reset");
      wr(4'h2, 32'hFFFF);
      rd(4'h2, 32'h0, 32'hFFFFFFFF, "unmapped read");
      wr(ADDR_MASK, 32'h3);
      rd(ADDR_MASK, 32'h3, 32'h3, "mask write");
      wr(ADDR_MASK, 32'h0);
      $display("test regs done");
   endtask : t_regs
   task automatic t_direct;
      int l0, m0;
      oscSet(1'b1, 7, 3);
      repeat (40) @(posedge clk);
      l0 = nLevel;
      m0 = nMaster;
      repeat (100) @(posedge clk);
      check(nLevel - l0 == 70, "direct duty");
      check(nMaster - m0 == 10, "direct rate");
      $display("test direct done");
   endtask : t_direct
   task automatic t_div;
      logic [15:0] cfg [5] = '{16'h0048, 16'h0049, 16'h004C, 16'h01D8,
         16'h01F8};
      int f [5] = '{6, 6, 6, 60, 60};
      int m0, c0;
      oscSet(1'b1, 3, 3);
      for (int i = 0; i < 5; i++) begin
         wr(ADDR_CONFIG, {16'h0, cfg[i]});
         repeat (12 * f[i]) @(posedge clk);
         m0 = nMaster;
         c0 = nCpu;
         repeat (36 * f[i]) @(posedge clk);
         check(nMaster - m0 == 6, "prescale rate");
         check(nCpu - c0 == (cfg[i][0] ? 3 : 6), "cpu ratio");
      end
      $display("test dividers done");
   endtask : t_div
   task automatic t_loop;
      int m0, n;
      wr(ADDR_MASK, 32'h2);
      oscSet(1'b1, 5, 5);
      wr(ADDR_CONFIG, 32'h0606);
      m0 = nMaster;
      repeat (200) @(posedge clk);
      check(nMaster - m0 < 80, "loop jumped");
      n = 0;
      while (locked !== 1'b1 && n < 25000) begin
         @(posedge clk);
         n++;
      end
      check(locked === 1'b1, "no lock");
      // first lock comes early in the ramp; let the rate settle
      repeat (16000) @(posedge clk);
      m0 = nMaster;
      repeat (1000) @(posedge clk);
      n = nMaster - m0;
      check(n >= 392 && n <= 408, "loop rate");
      rd(ADDR_STATUS, 32'h2, 32'h2, "lock status");
      check(irq === 1'b1, "lock irq");
      wr(ADDR_MASK, 32'h0);
      wr(ADDR_STATUS, 32'h2);
      $display("test loop done");
   endtask : t_loop
   task automatic t_wdog;
      int n;
      oscSet(1'b1, 3, 3);
      wr(ADDR_CONFIG, 32'h2);
      repeat (60) @(posedge clk);
      check(emerg === 1'b0, "early fallback");
      // lock event left over from the loop test
      wr(ADDR_STATUS, 32'h3);
      oscSet(1'b0, 3, 3);
      n = 0;
      while (emerg !== 1'b1 && n < 120) begin
         @(posedge clk);
         n++;
      end
      check(emerg === 1'b1 && irq === 1'b0, "no fallback");
      rd(ADDR_STATUS, 32'h1, 32'h1, "trip status");
      rd(ADDR_STATE, 32'h2, 32'h2, "state fallback");
      wr(ADDR_MASK, 32'h1);
      check(irq === 1'b1, "trip irq");
      oscSet(1'b1, 3, 3);
      wr(ADDR_STATUS, 32'h1);
      check(irq === 1'b0 && emerg === 1'b1, "clear or sticky");
      wr(ADDR_CONFIG, 32'h0);
      // mode change waits for a fallback master tick, one per 8 clk
      repeat (12) @(posedge clk);
      check(emerg === 1'b0, "fallback kept");
      oscSet(1'b0, 3, 3);
      repeat (150) @(posedge clk);
      check(irq === 1'b0 && emerg === 1'b0, "monitor on");
      rd(ADDR_STATUS, 32'h0, 32'h3, "status set");
      $display("test watchdog done");
   endtask : t_wdog
   task automatic conclude;
      $display("checks %0d mismatches %0d", samplesChecked, nMismatch);
      if (nMismatch == 0 && samplesChecked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : conclude
   initial begin
      {reset, oscOn} = 2'b10;
      {cyc, stb, we, osc} = 4'h0;
      {adr, wdat} = '0;
      {oscHi, oscLo, oscPh, nMaster, nCpu, nLevel} = '0;
      {nMismatch, samplesChecked} = '0;
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      t_regs;
      t_direct;
      t_div;
      t_loop;
      t_wdog;
      conclude;
   end
   // hang guard, about twice the expected run
   initial begin
      repeat (70000) @(posedge clk);
      nMismatch++;
      conclude;
   end
endmodule : tb_top
`default_nettype wire
